// File: gpe_consts.svh
// register offsets, widths, reset values and axi response codes for the port e gpio block
// assumes inclusion by bare name from the package and the design module
`ifndef GPE_CONSTS_SVH
`define GPE_CONSTS_SVH

// ==========================================================
// register byte offsets
`define GPE_OFS_DATA 5'h00
`define GPE_OFS_DIR 5'h04
`define GPE_OFS_PULL 5'h08
`define GPE_OFS_SLEW 5'h0c
`define GPE_OFS_DRIVE 5'h10

// ==========================================================
// widths and reset values
`define GPE_PORT_WIDTH 8
`define GPE_ADDR_WIDTH 5
`define GPE_RST_BYTE 8'h00

// ==========================================================
// axi response codes
`define GPE_RESP_OKAY 2'h0
`define GPE_RESP_SLVERR 2'h2

`endif

// File: gpe_pkg.sv
// types shared by the port e gpio block
// assumes gpe_consts.svh is on the include path
`default_nettype none
package gpe_pkg;
  `include "gpe_consts.svh"

  typedef logic [`GPE_PORT_WIDTH-1:0] gpe_byte_t;
  typedef logic [`GPE_ADDR_WIDTH-1:0] gpe_addr_t;

  // ==========================================================
  // register selector
  typedef enum logic [2:0] {
    gpe_sel_data = 3'h0,
    gpe_sel_dir = 3'h1,
    gpe_sel_pull = 3'h3,
    gpe_sel_slew = 3'h2,
    gpe_sel_drive = 3'h6,
    gpe_sel_none = 3'h7
  } gpe_sel_e;
endpackage
`default_nettype wire

// File: gpe_port.sv
// eight-bit general purpose port e with axi4-lite register slave
// assumes pin_in is already synchronous to aclk and pads resolve the wire
`include "gpe_consts.svh"
`default_nettype none

// Notes on behaviour
// - reading the data register gives the pin level for bits that are inputs.
// - reading the data register gives the latch for bits that are outputs.
// - a data register write updates all eight latch bits whatever the direction.
// - output bits drive the latch value onto their pins.
// - reset clears the latch but leaves every pin an undriven input with no pullup.
// - a clear direction bit disables the driver and reads return the pin.
// - a set direction bit enables the driver, reads return the latch, and direction reads back.
// - a pullup bit turns the pullup on when one and off when zero for inputs.
// - output pins never have the pullup on.
// - a slew bit enables slew limiting when set and disables it when clear.
// - the slew bit has no effect on input pins.
// - a drive bit selects low drive when zero and high drive when one for outputs; input pins always see low drive.
module gpe_port
  import gpe_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [`GPE_ADDR_WIDTH-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [`GPE_ADDR_WIDTH-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // port pins
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  output logic [7:0] pin_pullup_en,
  output logic [7:0] pin_slew_en,
  output logic [7:0] pin_drive_high
);

  // ==========================================================
  // address decode
  function automatic gpe_sel_e decode(input gpe_addr_t addr);
    gpe_sel_e sel;
    sel = gpe_sel_none;
    if (addr[1:0] == 2'h0) begin
      unique case (addr[4:2])
        3'h0: sel = gpe_sel_data;
        3'h1: sel = gpe_sel_dir;
        3'h2: sel = gpe_sel_pull;
        3'h3: sel = gpe_sel_slew;
        3'h4: sel = gpe_sel_drive;
        default: sel = gpe_sel_none;
      endcase
    end
    return sel;
  endfunction

  // ==========================================================
  // registers
  gpe_byte_t port_e_data_latch_reg;
  gpe_byte_t port_e_direction_reg;
  gpe_byte_t port_e_pullup_enable_reg;
  gpe_byte_t port_e_slew_control_reg;
  gpe_byte_t port_e_drive_strength_reg;

  // ==========================================================
  // write channel: address and data latched independently, either order
  logic aw_held_reg;
  logic w_held_reg;
  gpe_addr_t aw_addr_reg;
  logic [31:0] w_data_reg;
  logic w_lane0_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic wr_fire;
  gpe_sel_e wr_sel;

  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready = !w_held_reg && !bvalid_reg;
  assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
  assign wr_sel = decode(aw_addr_reg);
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      w_data_reg <= '0;
      w_lane0_reg <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_lane0_reg <= s_axi_wstrb[0];
    end else if (wr_fire) begin
      w_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= `GPE_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= (wr_sel == gpe_sel_none) ? `GPE_RESP_SLVERR : `GPE_RESP_OKAY;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // ==========================================================
  // register updates; only byte lane 0 carries data, other lanes ignored
  logic wr_en;
  gpe_byte_t wr_byte;
  assign wr_en = wr_fire && w_lane0_reg;
  assign wr_byte = w_data_reg[7:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_e_data_latch_reg <= `GPE_RST_BYTE;
    end else if (wr_en && wr_sel == gpe_sel_data) begin
      port_e_data_latch_reg <= wr_byte;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_e_direction_reg <= `GPE_RST_BYTE;
    end else if (wr_en && wr_sel == gpe_sel_dir) begin
      port_e_direction_reg <= wr_byte;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_e_pullup_enable_reg <= `GPE_RST_BYTE;
      port_e_slew_control_reg <= `GPE_RST_BYTE;
      port_e_drive_strength_reg <= `GPE_RST_BYTE;
    end else if (wr_en) begin
      if (wr_sel == gpe_sel_pull) begin
        port_e_pullup_enable_reg <= wr_byte;
      end
      if (wr_sel == gpe_sel_slew) begin
        port_e_slew_control_reg <= wr_byte;
      end
      if (wr_sel == gpe_sel_drive) begin
        port_e_drive_strength_reg <= wr_byte;
      end
    end
  end

  // ==========================================================
  // read channel: one read in flight, data registered at acceptance
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  gpe_sel_e rd_sel;
  gpe_byte_t rd_byte;
  gpe_byte_t data_view;

  assign s_axi_arready = !rvalid_reg;
  assign rd_sel = decode(s_axi_araddr);
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // per bit: latch where output, live pin where input
  assign data_view = (port_e_direction_reg & port_e_data_latch_reg)
    | (~port_e_direction_reg & pin_in);

  always_comb begin
    rd_byte = `GPE_RST_BYTE;
    unique case (rd_sel)
      gpe_sel_data: rd_byte = data_view;
      gpe_sel_dir: rd_byte = port_e_direction_reg;
      gpe_sel_pull: rd_byte = port_e_pullup_enable_reg;
      gpe_sel_slew: rd_byte = port_e_slew_control_reg;
      gpe_sel_drive: rd_byte = port_e_drive_strength_reg;
      gpe_sel_none: rd_byte = `GPE_RST_BYTE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= `GPE_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= {24'h000000, rd_byte};
      rresp_reg <= (rd_sel == gpe_sel_none) ? `GPE_RESP_SLVERR : `GPE_RESP_OKAY;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ==========================================================
  // pad controls; slew and drive are masked on inputs so the pad sees no stray setting
  assign pin_oe = port_e_direction_reg;
  assign pin_out = port_e_data_latch_reg & port_e_direction_reg;
  assign pin_pullup_en = port_e_pullup_enable_reg & ~port_e_direction_reg;
  assign pin_slew_en = port_e_slew_control_reg & port_e_direction_reg;
  assign pin_drive_high = port_e_drive_strength_reg & port_e_direction_reg;

endmodule
`default_nettype wire

// File: gpe_port_sva.sv
// checker for the port e pad controls and bus answers
// assumes it is bound onto gpe_port, whose port names it mirrors
`default_nettype none
module gpe_port_sva (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus answers
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pad controls
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_pullup_en,
  input wire logic [7:0] pin_slew_en
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================
  // pads
  in_undriven_a: assert property ((pin_out & ~pin_oe) == 8'h00)
    else $error("pin out high on input bit");
  out_no_pull_a: assert property ((pin_pullup_en & pin_oe) == 8'h00)
    else $error("pullup on output bit");
  in_no_slew_a: assert property ((pin_slew_en & ~pin_oe) == 8'h00)
    else $error("slew on input bit");
  reset_pins_a: assert property (disable iff (1'b0) !aresetn |=>
    pin_oe == 8'h00 && pin_pullup_en == 8'h00) else $error("pins active after reset");
  // pads may move only when a write completes
  pads_hold_a: assert property (!$rose(s_axi_bvalid) |->
    $stable(pin_oe) && $stable(pin_out)) else $error("pads moved without write");
  // ==========================================
  // bus
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  ar_gate_a: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("arready wrong");
  r_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read upper lanes set");
endmodule
bind gpe_port gpe_port_sva chk (.*);
`default_nettype wire

// File: gpe_board.sv
// board model for the eight port e pins
// assumes the bench sets which pins the board drives and to what
`default_nettype none
module gpe_board (
  // clock
  input wire logic aclk,
  // pad controls
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_pullup_en,
  // board side
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  output logic [7:0] pin_level
);
  timeunit 1ns;
  timeprecision 1ns;
  logic flip = 1'b0;
  // a floating pin toggles so a stale value never reads as right
  always @(posedge aclk) flip <= !flip;
  assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
    | (~pin_oe & ~ext_en & (pin_pullup_en | {8{flip}} & ~pin_pullup_en));
endmodule
`default_nettype wire

// File: gpe_port_tb.sv
// self-checking bench for gpe_port over axi4-lite
// assumes gpe_board models the pins
`include "gpe_consts.svh"
`default_nettype none
module gpe_port_tb;
  import gpe_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
  logic bv, rv, awr, wr_r, arr;
  logic [1:0] bresp, rresp;
  gpe_addr_t awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [7:0] pin_in, pin_out, oe, pull, slew, drv, ext_en = 8'h00, ext_val = 8'h00;
  int mismatches = 0, tests_run = 0;
  gpe_addr_t ofs [5] = '{`GPE_OFS_DATA, `GPE_OFS_DIR, `GPE_OFS_PULL, `GPE_OFS_SLEW,
    `GPE_OFS_DRIVE};
  always #12.5 aclk = ~aclk;
  gpe_port dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wr_r), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rready), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(oe), .pin_pullup_en(pull), .pin_slew_en(slew),
    .pin_drive_high(drv));
  gpe_board brd (.aclk(aclk), .pin_out(pin_out), .pin_oe(oe), .pin_pullup_en(pull),
    .ext_en(ext_en), .ext_val(ext_val), .pin_level(pin_in));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // ==========================================
  // bus cycles
  task automatic wr(input gpe_addr_t a, input gpe_byte_t d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    @(posedge aclk iff (awr && wr_r));
    awv <= 1'b0;
    wv <= 1'b0;
    @(posedge aclk iff bv);
    bready <= 1'b0;
    chk(bresp, er);
  endtask
  task automatic rd(input gpe_addr_t a, input gpe_byte_t ed, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    @(posedge aclk iff arr);
    arv <= 1'b0;
    @(posedge aclk iff rv);
    rready <= 1'b0;
    chk(rdata, {24'h0, ed});
    chk(rresp, er);
  endtask
  // ==========================================
  // scenarios
  task automatic t_reset();
    // board holds the inputs low so a floating pin cannot mask the reset value
    ext_en <= 8'hff;
    ext_val <= 8'h00;
    for (int k = 0; k < 5; k++) rd(ofs[k], 8'h00, 2'h0);
    chk({oe, pull, pin_out}, 24'h0);
  endtask
  task automatic t_regs();
    for (int k = 1; k < 5; k++) wr(ofs[k], 8'h96 ^ k[7:0], 2'h0);
    for (int k = 1; k < 5; k++) rd(ofs[k], 8'h96 ^ k[7:0], 2'h0);
  endtask
  task automatic t_io();
    wr(ofs[1], 8'hf0, 2'h0);
    ext_en <= 8'hff;
    ext_val <= 8'h3c;
    wr(ofs[0], 8'ha5, 2'h0);
    rd(ofs[0], 8'hac, 2'h0);
    chk({oe, pin_out}, 16'hf0a0);
    wr(ofs[1], 8'hff, 2'h0);
    rd(ofs[0], 8'ha5, 2'h0);
    wr(ofs[1], 8'h00, 2'h0);
    chk({oe, pin_out}, 16'h0);
    rd(ofs[0], 8'h3c, 2'h0);
  endtask
  task automatic t_ctl();
    wr(ofs[1], 8'hf0, 2'h0);
    for (int k = 2; k < 5; k++) wr(ofs[k], 8'hff, 2'h0);
    ext_en <= 8'h00;
    chk({pull, slew, drv}, 24'h0ff0f0);
    rd(ofs[0], 8'haf, 2'h0);
    wr(ofs[4], 8'h00, 2'h0);
    chk(drv, 8'h00);
  endtask
  task automatic t_err();
    wr(5'h14, 8'h55, 2'h2);
    rd(5'h14, 8'h00, 2'h2);
    rd(ofs[4], 8'h00, 2'h0);
  endtask
  task automatic end_of_test();
    $display("tests_run %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #60000;
    mismatches++;
    end_of_test();
  end
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_regs();
    t_io();
    t_ctl();
    t_err();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    end_of_test();
  end
endmodule
`default_nettype wire
